// file: core/smws_pkg.sv
package smws_pkg;

  // ----------------------------------------------------------------
  // image geometry
  // ----------------------------------------------------------------
  localparam int unsigned IMG_WORDS = 10;
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned IDX_W     = 4;
  localparam int unsigned JOIN_W    = 32;
  localparam logic [3:0]  IDX_LAST  = 4'h9;

  // ----------------------------------------------------------------
  // output image word positions and fields
  // ----------------------------------------------------------------
  localparam logic [3:0]  W_CONTROL   = 4'h0;
  localparam logic [3:0]  W_CFGWORD   = 4'h1;
  localparam logic [3:0]  W_SPEED_HI  = 4'h2;
  localparam logic [3:0]  W_SPEED_LO  = 4'h3;
  localparam logic [3:0]  W_STEPS     = 4'h4;
  localparam logic [3:0]  W_HYB_GAIN  = 4'h5;
  localparam logic [3:0]  W_ENC_PPT   = 4'h6;
  localparam logic [3:0]  W_IDLE_PCT  = 4'h7;
  localparam logic [3:0]  W_MOT_CUR   = 4'h8;
  localparam logic [3:0]  W_LOOP_GAIN = 4'h9;
  localparam int unsigned MODE_BIT    = 15;
  localparam int unsigned MOVE_BIT    = 0;

  // ----------------------------------------------------------------
  // input image status bits
  // ----------------------------------------------------------------
  localparam int unsigned ST_MODE_BIT    = 15;
  localparam int unsigned ST_VALID_BIT   = 14;
  localparam int unsigned ST_REFUSED_BIT = 13;
  localparam int unsigned ST_POWER_BIT   = 12;

  // ----------------------------------------------------------------
  // values after reset, error codes and the join scale
  // ----------------------------------------------------------------
  localparam logic [15:0] CFG_ERR_CODE = 16'h6408;
  localparam logic [15:0] NO_ERR_CODE  = 16'h0000;
  localparam logic [15:0] WORD_RST     = 16'h0000;
  localparam logic        MODE_RST     = 1'b0;
  localparam logic [15:0] JOIN_SCALE   = 16'h03E8;

  // ----------------------------------------------------------------
  // parameter ranges, inclusive
  // ----------------------------------------------------------------
  localparam logic signed [31:0] SPEED_MIN = 32'sh0000_0001;
  localparam logic signed [31:0] SPEED_MAX = 32'sh001E_847F;
  localparam logic signed [15:0] STEPS_MIN = 16'sh00C8;
  localparam logic signed [15:0] STEPS_MAX = 16'sh7FFF;
  localparam logic signed [15:0] HYB_MAX   = 16'sh0003;
  localparam logic signed [15:0] ENC_MAX   = 16'sh7FFF;
  localparam logic signed [15:0] IDLE_MAX  = 16'sh0064;
  localparam logic signed [15:0] CUR_MIN   = 16'sh0001;
  localparam logic signed [15:0] CUR_MAX   = 16'sh0028;
  localparam logic signed [15:0] LOOP_MIN  = 16'sh0001;
  localparam logic signed [15:0] LOOP_MAX  = 16'sh0050;

  // ----------------------------------------------------------------
  // frame handling states, gray from collect to check; check back to collect flips both bits
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SMWS_COLLECT = 2'b00,
    SMWS_JOIN    = 2'b01,
    SMWS_CHECK   = 2'b11
  } smws_state_t;

endpackage : smws_pkg

// file: core/smws_word_join.sv
`timescale 1ns/1ps
module smws_word_join
  import smws_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic signed [WORD_W-1:0] hiWord,
  input  wire logic signed [WORD_W-1:0] loWord,
  output logic signed      [JOIN_W-1:0] joined_ff
);

  // ----------------------------------------------------------------
  // pair rebuild
  // ----------------------------------------------------------------
  logic signed [JOIN_W-1:0] nxt_joined;
  logic signed [JOIN_W-1:0] hiScaled;

  // both words carry the sign, so a plain signed sum is exact
  always_comb begin
    hiScaled   = JOIN_W'(hiWord) * $signed({16'h0000, JOIN_SCALE});
    nxt_joined = hiScaled + JOIN_W'(loWord);
  end

  // registered so the range check sees a settled value
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      joined_ff <= '0;
    end else begin
      joined_ff <= nxt_joined;
    end
  end

endmodule : smws_word_join

// file: core/smws_core.sv
`timescale 1ns/1ps
module smws_core
  import smws_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              hostWrValid,
  input  wire logic              hostWrFirst,
  input  wire logic [WORD_W-1:0] hostWrData,
  input  wire logic              hostRdEn,
  input  wire logic [IDX_W-1:0]  hostRdIdx,
  output logic      [WORD_W-1:0] hostRdData_ff,
  output logic                   hostRdValid_ff,
  output logic                   cfgMode_ff,
  output logic                   cfgValid_ff,
  output logic                   motorPowerEn_ff,
  output logic                   moveStart_ff,
  output logic                   moveRefused_ff,
  output logic                   frameDone_ff
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic        [WORD_W-1:0] imgWords_ff [IMG_WORDS];
  logic        [IDX_W-1:0]  wrIdx_ff;
  logic                     wrOpen_ff;
  smws_state_t              state_ff;
  smws_state_t              nxt_state;
  logic        [WORD_W-1:0] errCode_ff;
  logic                     refusedSeen_ff;
  logic        [WORD_W-1:0] speedHiEcho_ff;
  logic        [WORD_W-1:0] speedLoEcho_ff;
  logic signed [JOIN_W-1:0] speedJoined;
  logic                     wrTake;
  logic        [IDX_W-1:0]  wrSlot;
  logic                     frameEnd;
  logic                     frameMode;
  logic                     cfgGood;
  logic                     moveAsk;
  logic                     checkNow;
  logic        [WORD_W-1:0] statusWord;
  logic        [WORD_W-1:0] rdWord;

  // ----------------------------------------------------------------
  // output image capture
  // ----------------------------------------------------------------
  // a first-word flag restarts the slot count, so a lost word costs
  // only one frame rather than shifting every frame after it
  always_comb begin
    wrSlot   = hostWrFirst ? W_CONTROL : wrIdx_ff;
    wrTake   = hostWrValid && (hostWrFirst || wrOpen_ff);
    frameEnd = wrTake && (wrSlot == IDX_LAST);
  end

  // slot counter; words past the tenth are dropped until a new first
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrIdx_ff  <= W_CONTROL;
      wrOpen_ff <= 1'b0;
    end else if (wrTake) begin
      wrIdx_ff  <= wrSlot + 4'h1;
      wrOpen_ff <= !frameEnd;
    end
  end

  // ten-word image store, one 16-bit word per slot
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < IMG_WORDS; i++) begin
        imgWords_ff[i] <= WORD_RST;
      end
    end else if (wrTake) begin
      imgWords_ff[wrSlot] <= hostWrData;
    end
  end

  // ----------------------------------------------------------------
  // pair rebuild of the starting speed
  // ----------------------------------------------------------------
  smws_word_join u_speed_join (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .hiWord    ($signed(imgWords_ff[W_SPEED_HI])),
    .loWord    ($signed(imgWords_ff[W_SPEED_LO])),
    .joined_ff (speedJoined)
  );

  // ----------------------------------------------------------------
  // frame sequencing
  // ----------------------------------------------------------------
  // one idle cycle lets the joiner register settle before the check
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SMWS_COLLECT: begin
        if (frameEnd) begin
          nxt_state = SMWS_JOIN;
        end
      end
      SMWS_JOIN: begin
        nxt_state = SMWS_CHECK;
      end
      SMWS_CHECK: begin
        nxt_state = SMWS_COLLECT;
      end
      default: begin
        nxt_state = SMWS_COLLECT;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= SMWS_COLLECT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // a frame arriving during the check is still stored; its mode is
  // judged only when its own last word lands in the collect state
  always_comb begin
    checkNow  = (state_ff == SMWS_CHECK);
    frameMode = imgWords_ff[W_CONTROL][MODE_BIT];
    moveAsk   = imgWords_ff[W_CONTROL][MOVE_BIT];
  end

  // ----------------------------------------------------------------
  // configuration range check
  // ----------------------------------------------------------------
  always_comb begin
    cfgGood = (speedJoined >= SPEED_MIN) && (speedJoined <= SPEED_MAX)
      && ($signed(imgWords_ff[W_STEPS]) >= STEPS_MIN)
      && ($signed(imgWords_ff[W_STEPS]) <= STEPS_MAX)
      && ($signed(imgWords_ff[W_HYB_GAIN]) >= 16'sh0000)
      && ($signed(imgWords_ff[W_HYB_GAIN]) <= HYB_MAX)
      && ($signed(imgWords_ff[W_ENC_PPT]) >= 16'sh0000)
      && ($signed(imgWords_ff[W_ENC_PPT]) <= ENC_MAX)
      && ($signed(imgWords_ff[W_IDLE_PCT]) >= 16'sh0000)
      && ($signed(imgWords_ff[W_IDLE_PCT]) <= IDLE_MAX)
      && ($signed(imgWords_ff[W_MOT_CUR]) >= CUR_MIN)
      && ($signed(imgWords_ff[W_MOT_CUR]) <= CUR_MAX)
      && ($signed(imgWords_ff[W_LOOP_GAIN]) >= LOOP_MIN)
      && ($signed(imgWords_ff[W_LOOP_GAIN]) <= LOOP_MAX);
  end

  // ----------------------------------------------------------------
  // mode selection
  // ----------------------------------------------------------------
  // reset lands in command mode; nothing survives reset, so the host
  // must send a fresh configuration every time
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfgMode_ff <= MODE_RST;
    end else if (checkNow) begin
      cfgMode_ff <= frameMode;
    end
  end

  // ----------------------------------------------------------------
  // configuration acceptance and motor power
  // ----------------------------------------------------------------
  // a rejected configuration drops power as well: running a motor on
  // a set the host believes it replaced would be worse than stopping
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfgValid_ff     <= 1'b0;
      motorPowerEn_ff <= 1'b0;
    end else if (checkNow && frameMode) begin
      cfgValid_ff     <= cfgGood;
      motorPowerEn_ff <= cfgGood;
    end
  end

  // error word; the same code marks a missing or a rejected set
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      errCode_ff <= CFG_ERR_CODE;
    end else if (checkNow && frameMode) begin
      errCode_ff <= cfgGood ? NO_ERR_CODE : CFG_ERR_CODE;
    end
  end

  // echo of the accepted speed pair, kept exactly as the host split it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      speedHiEcho_ff <= WORD_RST;
      speedLoEcho_ff <= WORD_RST;
    end else if (checkNow && frameMode && cfgGood) begin
      speedHiEcho_ff <= imgWords_ff[W_SPEED_HI];
      speedLoEcho_ff <= imgWords_ff[W_SPEED_LO];
    end
  end

  // ----------------------------------------------------------------
  // move commands
  // ----------------------------------------------------------------
  // the move bit is read only in command mode; one pulse per frame
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      moveStart_ff   <= 1'b0;
      moveRefused_ff <= 1'b0;
    end else begin
      moveStart_ff   <= checkNow && !frameMode && moveAsk && cfgValid_ff;
      moveRefused_ff <= checkNow && !frameMode && moveAsk
                        && !cfgValid_ff;
    end
  end

  // sticky refusal flag; an accepted move clears it, a new refusal
  // in the same cycle wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      refusedSeen_ff <= 1'b0;
    end else if (moveRefused_ff) begin
      refusedSeen_ff <= 1'b1;
    end else if (moveStart_ff || (checkNow && frameMode && cfgGood)) begin
      refusedSeen_ff <= 1'b0;
    end
  end

  // frame completion pulse, one cycle after the check
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frameDone_ff <= 1'b0;
    end else begin
      frameDone_ff <= checkNow;
    end
  end

  // ----------------------------------------------------------------
  // input image read port
  // ----------------------------------------------------------------
  always_comb begin
    statusWord                 = WORD_RST;
    statusWord[ST_MODE_BIT]    = cfgMode_ff;
    statusWord[ST_VALID_BIT]   = cfgValid_ff;
    statusWord[ST_REFUSED_BIT] = refusedSeen_ff;
    statusWord[ST_POWER_BIT]   = motorPowerEn_ff;
    case (hostRdIdx)
      W_CONTROL:  rdWord = statusWord;
      W_CFGWORD:  rdWord = errCode_ff;
      W_SPEED_HI: rdWord = speedHiEcho_ff;
      W_SPEED_LO: rdWord = speedLoEcho_ff;
      default:    rdWord = WORD_RST;
    endcase
  end

  // four readable slots; indices above three read as zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hostRdData_ff  <= WORD_RST;
      hostRdValid_ff <= 1'b0;
    end else begin
      hostRdValid_ff <= hostRdEn;
      if (hostRdEn) begin
        hostRdData_ff <= rdWord;
      end
    end
  end

endmodule : smws_core

// file: verif/smws_core_checker.sv
`timescale 1ns/1ps
module smws_core_checker
  import smws_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic              hostWrValid,
  input wire logic              hostWrFirst,
  input wire logic [WORD_W-1:0] hostWrData,
  input wire logic              hostRdEn,
  input wire logic [IDX_W-1:0]  hostRdIdx,
  input wire logic [WORD_W-1:0] hostRdData_ff,
  input wire logic              hostRdValid_ff,
  input wire logic              cfgMode_ff,
  input wire logic              cfgValid_ff,
  input wire logic              motorPowerEn_ff,
  input wire logic              moveStart_ff,
  input wire logic              moveRefused_ff,
  input wire logic              frameDone_ff
);
  // ------------------------------------------------
  // frame shapes and checks
  // ------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // nine more words with no restart; gapped frames never match
  sequence sTail;
    (hostWrValid && !hostWrFirst) [*8] ##1 (hostWrValid && !hostWrFirst);
  endsequence
  sequence sFrame;
    hostWrValid && hostWrFirst ##1 sTail;
  endsequence
  sequence sCfgFrame;
    hostWrValid && hostWrFirst && hostWrData[MODE_BIT] ##1 sTail;
  endsequence
  reset_cmd_mode_a: assert property (
    $fell(rst) |-> !cfgMode_ff && !cfgValid_ff && !motorPowerEn_ff)
    else $error("outputs not cleared by reset");
  frame_eval_a: assert property (
    sFrame |-> ##[3:4] frameDone_ff)
    else $error("ten word frame not evaluated");
  cfg_mode_sel_a: assert property (
    sCfgFrame |-> ##[3:4] (frameDone_ff && cfgMode_ff))
    else $error("mode bit did not select configuration");
  mode_on_frame_a: assert property (
    $changed(cfgMode_ff) |-> frameDone_ff)
    else $error("mode changed outside a frame");
  power_needs_cfg_a: assert property (
    motorPowerEn_ff |-> cfgValid_ff)
    else $error("power on without valid configuration");
  move_accept_a: assert property (
    moveStart_ff |-> frameDone_ff && cfgValid_ff && !moveRefused_ff)
    else $error("move started without valid configuration");
  move_refused_a: assert property (
    moveRefused_ff |-> frameDone_ff && !cfgValid_ff && !cfgMode_ff)
    else $error("move refused wrongly");
  rd_answer_a: assert property (
    hostRdEn |=> hostRdValid_ff)
    else $error("read not answered next cycle");
  rd_cause_a: assert property (
    hostRdValid_ff |-> $past(hostRdEn))
    else $error("read answer without request");
  err_code_a: assert property (
    hostRdValid_ff && $past(hostRdIdx) == 4'h1 |-> hostRdData_ff ==
      ($past(cfgValid_ff) ? NO_ERR_CODE : CFG_ERR_CODE))
    else $error("error code word wrong");
endmodule : smws_core_checker

bind smws_core smws_core_checker i_smws_core_checker (
  .ref_clk(ref_clk), .rst(rst), .hostWrValid(hostWrValid),
  .hostWrFirst(hostWrFirst), .hostWrData(hostWrData),
  .hostRdEn(hostRdEn), .hostRdIdx(hostRdIdx),
  .hostRdData_ff(hostRdData_ff), .hostRdValid_ff(hostRdValid_ff),
  .cfgMode_ff(cfgMode_ff), .cfgValid_ff(cfgValid_ff),
  .motorPowerEn_ff(motorPowerEn_ff), .moveStart_ff(moveStart_ff),
  .moveRefused_ff(moveRefused_ff), .frameDone_ff(frameDone_ff)
);

// file: verif/smws_host_model.sv
`timescale 1ns/1ps
module smws_host_model
  import smws_pkg::*;
(
  input  wire logic                        ref_clk,
  input  wire logic                        go,
  input  wire logic                        slow,
  input  wire logic [IMG_WORDS*WORD_W-1:0] img,
  output logic                             hostWrValid,
  output logic                             hostWrFirst,
  output logic      [WORD_W-1:0]           hostWrData,
  output logic                             busy
);
  // ------------------------------------------------
  // frame sender
  // ------------------------------------------------
  // idle data shows the inverse word so a stale copy never passes
  initial begin
    hostWrValid = 1'b0;
    hostWrFirst = 1'b0;
    hostWrData  = 16'h0000;
    busy        = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (go) begin
        busy <= 1'b1;
        for (int i = 0; i < IMG_WORDS; i++) begin
          hostWrValid <= 1'b1;
          hostWrFirst <= (i == 0);
          hostWrData  <= img[i*WORD_W +: WORD_W];
          @(posedge ref_clk);
          if (slow) begin
            hostWrValid <= 1'b0;
            hostWrFirst <= 1'b0;
            hostWrData  <= ~img[i*WORD_W +: WORD_W];
            @(posedge ref_clk);
          end
        end
        hostWrValid <= 1'b0;
        hostWrFirst <= 1'b0;
        hostWrData  <= ~img[(IMG_WORDS-1)*WORD_W +: WORD_W];
        busy        <= 1'b0;
      end
    end
  end
endmodule : smws_host_model

// file: verif/stepper_mode_and_word_split_tb_top.sv
`timescale 1ns/1ps
module stepper_mode_and_word_split_tb_top;
  import smws_pkg::*;
  // ------------------------------------------------
  // signals
  // ------------------------------------------------
  logic                        ref_clk = 1'b0;
  logic                        rst = 1'b1;
  logic                        go = 1'b0;
  logic                        slow = 1'b0;
  logic                        hostRdEn = 1'b0;
  logic [IDX_W-1:0]            hostRdIdx = 4'h0;
  logic [IMG_WORDS*WORD_W-1:0] img = '0;
  logic                        hostWrValid, hostWrFirst, hostRdValid_ff;
  logic                        cfgMode_ff, cfgValid_ff, motorPowerEn_ff;
  logic                        moveStart_ff, moveRefused_ff, frameDone_ff;
  logic                        busy;
  logic                        expValid = 1'b0;
  logic [WORD_W-1:0]           hostWrData, hostRdData_ff;
  logic [4:0]                  seenF;
  logic [4:0]                  fq[$];
  logic [15:0]                 rq[$];
  int                          n_errors = 0;
  int                          check_count = 0;
  int                          cyc = 0;
  int                          seed = 35;
  int spdTab[7] = '{12, 12345, 1234567, -7654321, 0, 2000000, 1999999};

  assign seenF = {cfgMode_ff, cfgValid_ff, motorPowerEn_ff, moveStart_ff,
                  moveRefused_ff};

  smws_core i_smws_core (
    .ref_clk(ref_clk), .rst(rst), .hostWrValid(hostWrValid),
    .hostWrFirst(hostWrFirst), .hostWrData(hostWrData),
    .hostRdEn(hostRdEn), .hostRdIdx(hostRdIdx),
    .hostRdData_ff(hostRdData_ff), .hostRdValid_ff(hostRdValid_ff),
    .cfgMode_ff(cfgMode_ff), .cfgValid_ff(cfgValid_ff),
    .motorPowerEn_ff(motorPowerEn_ff), .moveStart_ff(moveStart_ff),
    .moveRefused_ff(moveRefused_ff), .frameDone_ff(frameDone_ff));
  smws_host_model i_smws_host_model (
    .ref_clk(ref_clk), .go(go), .slow(slow), .img(img),
    .hostWrValid(hostWrValid), .hostWrFirst(hostWrFirst),
    .hostWrData(hostWrData), .busy(busy));

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  always #10 ref_clk = ~ref_clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test;
    // a result that never showed up is a mismatch, not a silent pass
    if (fq.size() != 0 || rq.size() != 0) n_errors++;
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // one frame; speed split by thousands, sign kept in both words
  task automatic frame(input logic mode, input logic mv, input int spd,
                       input int steps, input logic slw);
    logic ok;
    ok = spd >= SPEED_MIN && spd <= SPEED_MAX && steps >= STEPS_MIN;
    fq.push_back(mode ? {1'b1, ok, ok, 2'b00}
                      : {1'b0, expValid, expValid, mv & expValid,
                         mv & ~expValid});
    if (mode) expValid = ok;
    img  <= {16'h0028, 16'h0014, 16'h0032, 16'h0000, 16'h0001, 16'(steps),
             16'(spd % 1000), 16'(spd / 1000), 16'h0000, mode, 14'h0, mv};
    slow <= slw;
    go   <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    for (int n = 0; n < 60 && (n < 2 || busy); n++) @(posedge ref_clk);
    repeat (6) @(posedge ref_clk);
  endtask : frame

  task automatic rd(input logic [3:0] idx, input logic [15:0] exp);
    rq.push_back(exp);
    hostRdEn  <= 1'b1;
    hostRdIdx <= idx;
    @(posedge ref_clk);
    hostRdEn <= 1'b0;
    @(posedge ref_clk);
  endtask : rd

  // ------------------------------------------------
  // watchers and run limit
  // ------------------------------------------------
  // results are matched in order against what the driver noted
  always @(posedge ref_clk) begin
    cyc++;
    if (frameDone_ff === 1'b1 && fq.size() > 0)
      chk({11'h0, seenF}, {11'h0, fq.pop_front()});
    else if (frameDone_ff === 1'b1)
      chk(16'h0001, 16'h0000);
    if (hostRdValid_ff === 1'b1 && rq.size() > 0)
      chk(hostRdData_ff, rq.pop_front());
    if (cyc == 3000) begin
      n_errors++;
      finish_test();
    end
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk({15'h0, cfgMode_ff}, 16'h0000);
    rd(4'h1, CFG_ERR_CODE);
    frame(1'b0, 1'b1, 12345, 200, 1'b0);
    rd(4'h0, 16'h2000);
    foreach (spdTab[i]) frame(1'b1, 1'b0, spdTab[i], 200, i[0]);
    rd(4'h2, 16'h07CF);
    rd(4'h3, 16'h03E7);
    rd(4'h1, NO_ERR_CODE);
    rd(4'h0, 16'hD000);
    rd(4'h7, 16'h0000);
    frame(1'b1, 1'b0, 5000, 199, 1'b0);
    frame(1'b1, 1'b0, 1, 200, 1'b1);
    frame(1'b0, 1'b1, 0, 0, 1'b0);
    frame(1'b1, 1'b0, -1, 200, 1'b0);
    repeat (14) frame(1'($random(seed)), 1'($random(seed)),
                      $random(seed) % 2500000, 200, 1'($random(seed)));
    rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    expValid = 1'b0;
    @(posedge ref_clk);
    chk({14'h0, cfgValid_ff, motorPowerEn_ff}, 16'h0000);
    rd(4'h1, CFG_ERR_CODE);
    frame(1'b0, 1'b1, 12, 200, 1'b0);
    frame(1'b1, 1'b0, 12, 200, 1'b0);
    frame(1'b0, 1'b1, 12, 200, 1'b1);
    finish_test();
  end
endmodule : stepper_mode_and_word_split_tb_top
